// [tb/mcs_motor_model.sv]
// Motor-side model: finishes a requested move after a settle time.
// Assumes move requests arrive as one-cycle pulses on clk_i.
`timescale 1ns/1ns
`default_nettype none
module mcs_motor_model (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic move_req_i,
    input wire logic [7:0] settle_i,
    output logic move_done_o
);
    logic [7:0] cnt_q;
    logic busy_q;
    // Settle count lets the bench ask for a slow axis
    always_ff @(posedge clk_i) begin
        move_done_o <= 1'b0;
        if (!rstn_i) begin
            busy_q <= 1'b0;
            cnt_q <= 8'h00;
        end else if (move_req_i) begin
            busy_q <= 1'b1;
            cnt_q <= settle_i;
        end else if (busy_q && cnt_q == 8'h00) begin
            busy_q <= 1'b0;
            move_done_o <= 1'b1;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule
`default_nettype wire

// [tb/mcs_top_bench.sv]
// Self-checking bench for the setup block and its register port.
// Assumes mcs_defs.svh on the include path; short millisecond.
`timescale 1ns/1ns
`default_nettype none
`include "mcs_defs.svh"
module mcs_top_bench;
    localparam int unsigned CPM = 10;
    logic clk_i = 1'b0, rstn_i = 1'b0;
    logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
    logic arvalid = 1'b0, rready = 1'b1;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic signed [15:0] meas_v = 16'h0000, meas_w = 16'h0000, act_v, act_w;
    logic cfg_reload = 1'b0, servo_on = 1'b0, home_done = 1'b0;
    logic comm_active, comm_done, move_done, move_req, pos_load;
    logic [15:0] comm_current, ofs;
    logic signed [31:0] home_offset = 32'h0000_0000;
    logic signed [31:0] move_amount, pos_value;
    logic [7:0] settle = 8'h05;
    mcs_pkg::mcs_static_t static_o;
    int miscompares = 0, total_checks = 0, cyc = 0, n, moves = 0;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    logic [33:0] note;
    logic [15:0] idx_t[9] = '{`MCS_IDX_V_OFS, `MCS_IDX_W_OFS, `MCS_IDX_PITCH,
        `MCS_IDX_SCALE, `MCS_IDX_METHOD, `MCS_IDX_CUR, `MCS_IDX_TIME,
        `MCS_IDX_GRATING, `MCS_IDX_HOME};
    logic [15:0] rst_t[9] = '{16'h0000, 16'h0000, 16'h0960, 16'h03E8,
        16'h0000, 16'h01F4, 16'h03E8, 16'h0028, 16'h0000};
    // Index, value, expected response
    logic [33:0] rng_t[12] = '{{16'h2016, 16'h03E9, 2'b10},
        {16'h2016, 16'hFC17, 2'b10}, {16'h2016, 16'h03E8, 2'b00},
        {16'h2016, 16'hFC18, 2'b00}, {16'h201B, 16'h03E9, 2'b10},
        {16'h201C, 16'h01F3, 2'b10}, {16'h201C, 16'h1389, 2'b10},
        {16'h201C, 16'h1388, 2'b00}, {16'h201A, 16'h0003, 2'b10},
        {16'h201E, 16'h0002, 2'b10}, {16'h2030, 16'h0000, 2'b10},
        {16'h2040, 16'h0000, 2'b11}};

    mcs_top #(.CYC_PER_MS(CPM)) uut (.clk_i(clk_i), .rstn_i(rstn_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .meas_v_i(meas_v),
        .meas_w_i(meas_w), .act_v_o(act_v), .act_w_o(act_w),
        .cfg_reload_i(cfg_reload), .static_o(static_o),
        .servo_on_i(servo_on), .comm_active_o(comm_active),
        .comm_done_o(comm_done), .comm_current_o(comm_current),
        .home_done_i(home_done), .home_offset_i(home_offset),
        .move_done_i(move_done), .move_req_o(move_req),
        .move_amount_o(move_amount), .pos_load_o(pos_load),
        .pos_value_o(pos_value));
    mcs_motor_model motor (.clk_i(clk_i), .rstn_i(rstn_i),
        .move_req_i(move_req), .settle_i(settle), .move_done_o(move_done));

    ////////////////////////////////////////////////////////////////////////
    // Clock, hang guard and move counter
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (move_req) moves++;
        if (cyc == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic chk(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Register answers are matched to the oldest note
    always @(posedge clk_i) begin
        if (bvalid && bready) begin
            chk("bresp", {30'h0, bq.pop_front()}, {30'h0, bresp});
        end
        if (rvalid && rready) begin
            note = rq.pop_front();
            chk("rresp", {30'h0, note[33:32]}, {30'h0, rresp});
            chk("rdata", note[31:0], rdata);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register bus master; byte address is four times the index
    task automatic wr(input logic [15:0] idx, input logic [15:0] val,
                      input logic [1:0] resp);
        bq.push_back(resp);
        awaddr <= {idx[13:0], 2'b00};
        wdata <= {16'h0000, val};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge clk_i); while (!bvalid);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [1:0] resp,
                      input logic [31:0] val);
        rq.push_back({resp, val});
        araddr <= {idx[13:0], 2'b00};
        arvalid <= 1'b1;
        do @(posedge clk_i); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk_i); while (!rvalid);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        n = $urandom(2);
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        for (int i = 0; i < 9; i++) begin
            rd(idx_t[i], 2'b00, {16'h0, rst_t[i]});
        end
        chk("static", 64'h0960_03E8_0000_0028, static_o);
        $display("test reset_values done");
        for (int i = 0; i < 12; i++) begin
            wr(rng_t[i][33:18], rng_t[i][17:2], rng_t[i][1:0]);
        end
        rd(16'h2016, 2'b00, 32'h0000_FC18);
        rd(16'h201C, 2'b00, 32'h0000_1388);
        rd(16'h201B, 2'b00, 32'h0000_01F4);
        rd(16'h2040, 2'b11, 32'h0000_0000);
        $display("test ranges done");
        ofs = 16'($urandom_range(2000)) - 16'd1000;
        wr(16'h2016, ofs, 2'b00);
        wr(16'h2017, 16'h012C, 2'b00);
        for (int i = 0; i < 8; i++) begin
            meas_v <= 16'($urandom_range(10000)) - 16'd5000;
            meas_w <= 16'($urandom_range(10000)) - 16'd5000;
            repeat (2) @(posedge clk_i);
            chk("act_v", {16'h0, meas_v - ofs}, {16'h0, act_v});
            chk("act_w", {16'h0, meas_w}, {16'h0, act_w});
        end
        $display("test offsets done");
        servo_on <= 1'b1;
        repeat (5) @(posedge clk_i);
        chk("idle", 32'h0, {31'h0, comm_active});
        servo_on <= 1'b0;
        wr(16'h2018, 16'h0123, 2'b00);
        wr(16'h2019, 16'h0456, 2'b00);
        wr(16'h201A, 16'h0001, 2'b00);
        wr(16'h201D, 16'h0050, 2'b00);
        rd(16'h2030, 2'b00, 32'h0000_0008);
        chk("static", 64'h0960_03E8_0000_0028, static_o);
        cfg_reload <= 1'b1;
        @(posedge clk_i);
        cfg_reload <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("static", 64'h0123_0456_0001_0050, static_o);
        $display("test reload done");
        wr(16'h201B, 16'h02BC, 2'b00);
        wr(16'h201C, 16'h01F4, 2'b00);
        servo_on <= 1'b1;
        n = 0;
        while (!comm_active && n < 20) begin @(posedge clk_i); n++; end
        n = 0;
        while (comm_active && n < 6000) begin
            @(posedge clk_i);
            n++;
            if (n == 100) chk("cur", 32'h2BC, {16'h0, comm_current});
        end
        chk("comm_len", 500 * CPM, n);
        chk("done", 32'h1, {31'h0, comm_done});
        chk("cur", 32'h0, {16'h0, comm_current});
        rd(16'h2030, 2'b00, 32'h0000_0002);
        $display("test commutation done");
        home_offset <= $urandom;
        home_done <= 1'b1;
        @(posedge clk_i);
        home_done <= 1'b0;
        n = 0;
        while (!pos_load && n < 20) begin @(posedge clk_i); n++; end
        chk("pos_value", home_offset, pos_value);
        chk("moves", 32'h0, moves);
        wr(16'h201E, 16'h0001, 2'b00);
        settle <= 8'h1E;
        home_done <= 1'b1;
        @(posedge clk_i);
        home_done <= 1'b0;
        n = 0;
        while (!move_req && n < 20) begin @(posedge clk_i); n++; end
        chk("move_amount", home_offset, move_amount);
        n = 0;
        while (!pos_load && n < 80) begin @(posedge clk_i); n++; end
        chk("pos_value", 32'h0, pos_value);
        chk("settle", 32'h1, {31'h0, n > 30});
        $display("test homing done");
        complete_run();
    end
endmodule
`default_nettype wire

// [verilog/mcs_comm_timer.sv]
// Initial-angle commutation sequencer with millisecond timebase.
// Assumes servo_on_i and settings come from logic on clk_i.
`timescale 1ns/1ns
`default_nettype none
`include "mcs_defs.svh"
module mcs_comm_timer #(
    parameter int unsigned CYC_PER_MS = `MCS_CYC_PER_MS
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic enable_i,
    input wire logic servo_on_i,
    input wire logic [15:0] time_ms_i,
    output logic active_o,
    output logic done_o,
    output mcs_pkg::mcs_comm_state_t state_o
);
    mcs_pkg::mcs_comm_state_t state_q, state_d;
    logic [31:0] pre_q;
    logic [15:0] ms_q;
    logic servo_q;
    wire servo_rise = servo_on_i & ~servo_q;
    wire ms_tick = (pre_q == CYC_PER_MS - 1);
    // Live time setting: a change during a run moves the end point
    wire expired = ms_tick & (ms_q + 16'h0001 >= time_ms_i);

    // A completed run ends commutation for good; servo-off mid-run returns to idle, so a later servo-on commutates again
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            mcs_pkg::CM_IDLE: if (enable_i && servo_rise) begin
                state_d = mcs_pkg::CM_RUN;
            end
            mcs_pkg::CM_RUN: if (!servo_on_i) begin
                state_d = mcs_pkg::CM_IDLE;
            end else if (expired) begin
                state_d = mcs_pkg::CM_DONE;
            end
            mcs_pkg::CM_DONE: state_d = mcs_pkg::CM_DONE;
        endcase
    end

    // Prescaler and millisecond count run only inside a run
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state_q <= mcs_pkg::CM_IDLE;
            pre_q <= 32'h0000_0000;
            ms_q <= 16'h0000;
            servo_q <= 1'b0;
        end else begin
            state_q <= state_d;
            servo_q <= servo_on_i;
            if (state_q != mcs_pkg::CM_RUN || state_d != mcs_pkg::CM_RUN
                || ms_tick) begin
                pre_q <= 32'h0000_0000;
            end else begin
                pre_q <= pre_q + 32'h0000_0001;
            end
            if (state_d != mcs_pkg::CM_RUN) begin
                ms_q <= 16'h0000;
            end else if (ms_tick) begin
                ms_q <= ms_q + 16'h0001;
            end
        end
    end

    assign active_o = (state_q == mcs_pkg::CM_RUN);
    assign done_o = (state_q == mcs_pkg::CM_DONE);
    assign state_o = state_q;

    // A run never outlasts the configured time
    property p_run_bounded;
        @(posedge clk_i) disable iff (!rstn_i)
        active_o |-> (ms_q < time_ms_i) || (time_ms_i == 16'h0000);
    endproperty
    a_run_bounded: assert property (p_run_bounded)
        else $error("commutation ran past its time");
endmodule
`default_nettype wire

// [verilog/mcs_defs.svh]
// Register indices, reset values, ranges and timing for the setup block.
// Assumes inclusion by bare name from the bench and the design files.
// What this block does
// - Actual phase current is measured minus offset.
// - Offsets signed, -1000 to 1000, default zero.
// - Third-phase offset is stored but never applied.
// - Pole pitch spans 360 electrical degrees, default 2400.
// - Scale resolution is nanometres per count, default 1000.
// - Method 0 none/hall, 1 first servo-on, 2 reserved.
// - Commutation current 0 to 1000, default 500.
// - Commutation lasts 500 to 5000 ms, default 1000.
// - Grating period is one sine cycle, default 40.
// - Behaviour 0: no move, position becomes home offset.
// - Behaviour 1: move by offset, then position zero.
`ifndef MCS_DEFS_SVH
`define MCS_DEFS_SVH
// Printed indices; byte address is four times the index
`define MCS_IDX_V_OFS 16'h2016
`define MCS_IDX_W_OFS 16'h2017
`define MCS_IDX_PITCH 16'h2018
`define MCS_IDX_SCALE 16'h2019
`define MCS_IDX_METHOD 16'h201A
`define MCS_IDX_CUR 16'h201B
`define MCS_IDX_TIME 16'h201C
`define MCS_IDX_GRATING 16'h201D
`define MCS_IDX_HOME 16'h201E
`define MCS_IDX_STATUS 16'h2030
// Reset values
`define MCS_RST_V_OFS 16'h0000
`define MCS_RST_W_OFS 16'h0000
`define MCS_RST_PITCH 16'h0960
`define MCS_RST_SCALE 16'h03E8
`define MCS_RST_METHOD 16'h0000
`define MCS_RST_CUR 16'h01F4
`define MCS_RST_TIME 16'h03E8
`define MCS_RST_GRATING 16'h0028
`define MCS_RST_HOME 16'h0000
// Accepted ranges
`define MCS_OFS_MIN (-16'sd1000)
`define MCS_OFS_MAX 16'sd1000
`define MCS_CUR_MAX 16'h03E8
`define MCS_TIME_MIN 16'h01F4
`define MCS_TIME_MAX 16'h1388
`define MCS_METHOD_MAX 16'h0002
`define MCS_HOME_MAX 16'h0001
`define MCS_METHOD_ON_SERVO 16'h0001
// Timing
`define MCS_MS_NS 1000000
`define MCS_CLK_NS 10
`define MCS_CYC_PER_MS (`MCS_MS_NS / `MCS_CLK_NS)
// AXI responses
`define MCS_RESP_OKAY 2'b00
`define MCS_RESP_SLVERR 2'b10
`define MCS_RESP_DECERR 2'b11
`endif

// [verilog/mcs_pkg.sv]
// Types shared by the setup block and its commutation timer.
// Assumes mcs_defs.svh on the include path.
package mcs_pkg;
    // Settings that only change on a reload
    typedef struct packed {
        logic [15:0] pitch;
        logic [15:0] scale;
        logic [15:0] method;
        logic [15:0] grating;
    } mcs_static_t;
    typedef enum logic [1:0] {CM_IDLE, CM_RUN, CM_DONE} mcs_comm_state_t;
    typedef enum logic [1:0] {HM_IDLE, HM_MOVE} mcs_home_state_t;
endpackage

// [verilog/mcs_top.sv]
// Motor feedback and commutation setup block with AXI4-Lite registers.
// Assumes measured currents, servo and homing events on clk_i.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "mcs_defs.svh"
module mcs_top #(
    parameter int unsigned CYC_PER_MS = `MCS_CYC_PER_MS
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    // AXI4-Lite slave
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Current path
    input wire logic signed [15:0] meas_v_i,
    input wire logic signed [15:0] meas_w_i,
    output logic signed [15:0] act_v_o,
    output logic signed [15:0] act_w_o,
    // Static settings towards the control loops
    input wire logic cfg_reload_i,
    output mcs_pkg::mcs_static_t static_o,
    // Commutation
    input wire logic servo_on_i,
    output logic comm_active_o,
    output logic comm_done_o,
    output logic [15:0] comm_current_o,
    // Homing
    input wire logic home_done_i,
    input wire logic signed [31:0] home_offset_i,
    input wire logic move_done_i,
    output logic move_req_o,
    output logic signed [31:0] move_amount_o,
    output logic pos_load_o,
    output logic signed [31:0] pos_value_o
);
    localparam int NREG = 9;
    localparam logic [15:0] IDX_BASE = `MCS_IDX_V_OFS;

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [15:0] cfg_q [NREG];
    logic [15:0] rst_val [NREG];
    assign rst_val[0] = `MCS_RST_V_OFS;
    assign rst_val[1] = `MCS_RST_W_OFS;
    assign rst_val[2] = `MCS_RST_PITCH;
    assign rst_val[3] = `MCS_RST_SCALE;
    assign rst_val[4] = `MCS_RST_METHOD;
    assign rst_val[5] = `MCS_RST_CUR;
    assign rst_val[6] = `MCS_RST_TIME;
    assign rst_val[7] = `MCS_RST_GRATING;
    assign rst_val[8] = `MCS_RST_HOME;

    ////////////////////////////////////////////////////////////////////////
    // Write channel
    logic awready_q, wready_q, bvalid_q;
    logic [1:0] bresp_q;
    logic [15:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    wire wr_go = ~awready_q & ~wready_q & ~bvalid_q;
    wire [13:0] wr_idx = awaddr_q[15:2];
    wire [15:0] wr_slot = {2'b00, wr_idx} - IDX_BASE;
    wire wr_hit = (awaddr_q[1:0] == 2'b00) && ({2'b00, wr_idx} >= IDX_BASE)
        && (wr_slot < 16'(NREG));
    wire wr_status = (awaddr_q[1:0] == 2'b00)
        && ({2'b00, wr_idx} == `MCS_IDX_STATUS);
    wire [3:0] wr_sel = wr_slot[3:0];
    // Byte lanes merge over the stored value
    wire [15:0] wr_old = wr_hit ? cfg_q[wr_sel] : 16'h0000;
    wire [15:0] wr_val = {wstrb_q[1] ? wdata_q[15:8] : wr_old[15:8],
        wstrb_q[0] ? wdata_q[7:0] : wr_old[7:0]};
    wire signed [15:0] wr_sval = wr_val;

    // Out-of-range values are refused with SLVERR and not stored
    logic wr_ok;
    always_comb begin
        unique case (wr_sel)
            4'd0, 4'd1: wr_ok = (wr_sval >= `MCS_OFS_MIN)
                && (wr_sval <= `MCS_OFS_MAX);
            4'd2, 4'd3, 4'd7: wr_ok = (wr_val != 16'h0000);
            4'd4: wr_ok = (wr_val <= `MCS_METHOD_MAX);
            4'd5: wr_ok = (wr_val <= `MCS_CUR_MAX);
            4'd6: wr_ok = (wr_val >= `MCS_TIME_MIN)
                && (wr_val <= `MCS_TIME_MAX);
            4'd8: wr_ok = (wr_val <= `MCS_HOME_MAX);
            default: wr_ok = 1'b0;
        endcase
    end
    wire wr_commit = wr_go & wr_hit & wr_ok;

    // Address and data are taken in either order, then answered together
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= `MCS_RESP_OKAY;
            awaddr_q <= 16'h0000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && awready_q) begin
                awready_q <= 1'b0;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_q) begin
                wready_q <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? (wr_ok ? `MCS_RESP_OKAY
                    : `MCS_RESP_SLVERR)
                    : (wr_status ? `MCS_RESP_SLVERR : `MCS_RESP_DECERR);
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // One flop bank per register
    for (genvar i = 0; i < NREG; i++) begin : g_reg
        always_ff @(posedge clk_i) begin
            if (!rstn_i) begin
                cfg_q[i] <= rst_val[i];
            end else if (wr_commit && wr_sel == 4'(i)) begin
                cfg_q[i] <= wr_val;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Static settings: held until a reload, as after a power cycle
    mcs_pkg::mcs_static_t static_q;
    logic reload_pend_q;
    wire static_diff = (static_q.pitch != cfg_q[2])
        || (static_q.scale != cfg_q[3]) || (static_q.method != cfg_q[4])
        || (static_q.grating != cfg_q[7]);
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            static_q <= '{`MCS_RST_PITCH,
                `MCS_RST_SCALE,
                `MCS_RST_METHOD,
                `MCS_RST_GRATING};
            reload_pend_q <= 1'b0;
        end else begin
            if (cfg_reload_i) begin
                static_q <= '{cfg_q[2], cfg_q[3], cfg_q[4],
                    cfg_q[7]};
            end
            reload_pend_q <= ~cfg_reload_i & static_diff;
        end
    end
    // Pitch, resolution and grating go out unchanged in their own units
    assign static_o = static_q;

    ////////////////////////////////////////////////////////////////////////
    // V current correction with saturation to 16 bits
    wire signed [16:0] v_diff = 17'(meas_v_i) - 17'($signed(cfg_q[0]));
    wire v_hi = (v_diff[16:15] == 2'b01);
    wire v_lo = (v_diff[16:15] == 2'b10);
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            act_v_o <= 16'sh0000;
            act_w_o <= 16'sh0000;
        end else begin
            act_v_o <= v_hi ? 16'sh7FFF : (v_lo ? 16'sh8000
                : v_diff[15:0]);
            // W passes through as measured on meas_w_i; its offset never applies
            act_w_o <= meas_w_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Commutation
    mcs_pkg::mcs_comm_state_t comm_state;
    logic comm_run;
    logic comm_end;
    mcs_comm_timer #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_comm (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .enable_i(static_q.method == `MCS_METHOD_ON_SERVO),
        .servo_on_i(servo_on_i),
        .time_ms_i(cfg_q[6]),
        .active_o(comm_run),
        .done_o(comm_end),
        .state_o(comm_state)
    );
    // Current setting acts at once, even mid-run
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            comm_active_o <= 1'b0;
            comm_done_o <= 1'b0;
            comm_current_o <= 16'h0000;
        end else begin
            comm_active_o <= comm_run;
            comm_done_o <= comm_end;
            comm_current_o <= comm_run ? cfg_q[5] : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Homing completion
    mcs_pkg::mcs_home_state_t home_q;
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            home_q <= mcs_pkg::HM_IDLE;
            move_req_o <= 1'b0;
            move_amount_o <= 32'sh0000_0000;
            pos_load_o <= 1'b0;
            pos_value_o <= 32'sh0000_0000;
        end else begin
            move_req_o <= 1'b0;
            pos_load_o <= 1'b0;
            unique case (home_q)
                mcs_pkg::HM_IDLE: if (home_done_i) begin
                    if (cfg_q[8][0]) begin
                        move_req_o <= 1'b1;
                        move_amount_o <= home_offset_i;
                        home_q <= mcs_pkg::HM_MOVE;
                    end else begin
                        pos_load_o <= 1'b1;
                        pos_value_o <= home_offset_i;
                    end
                end
                mcs_pkg::HM_MOVE: if (move_done_i) begin
                    pos_load_o <= 1'b1;
                    pos_value_o <= 32'sh0000_0000;
                    home_q <= mcs_pkg::HM_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel
    logic arready_q, rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    wire [13:0] rd_idx = s_axi_araddr[15:2];
    wire [15:0] rd_slot = {2'b00, rd_idx} - IDX_BASE;
    wire rd_aligned = (s_axi_araddr[1:0] == 2'b00);
    wire rd_hit = rd_aligned && ({2'b00, rd_idx} >= IDX_BASE)
        && (rd_slot < 16'(NREG));
    wire rd_status = rd_aligned && ({2'b00, rd_idx} == `MCS_IDX_STATUS);
    // Status: commutation state, homing move, reload pending
    wire [15:0] status_word = {12'h000, reload_pend_q,
        home_q == mcs_pkg::HM_MOVE, comm_state};
    wire [15:0] rd_word = rd_hit ? cfg_q[rd_slot[3:0]]
        : (rd_status ? status_word : 16'h0000);
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rresp_q <= `MCS_RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= {16'h0000, rd_word};
            rresp_q <= (rd_hit || rd_status) ? `MCS_RESP_OKAY
                : `MCS_RESP_DECERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_v_corr;
        @(posedge clk_i) disable iff (!rstn_i)
        ##1 (!$past(v_hi) && !$past(v_lo)) |->
            act_v_o == $past(meas_v_i) - $signed($past(cfg_q[0]));
    endproperty
    a_v_corr: assert property (p_v_corr)
        else $error("V current not offset-corrected");

    property p_w_raw;
        @(posedge clk_i) disable iff (!rstn_i)
        ##1 act_w_o == $past(meas_w_i);
    endproperty
    a_w_raw: assert property (p_w_raw)
        else $error("W offset was applied");

    property p_ofs_range;
        @(posedge clk_i) disable iff (!rstn_i)
        $signed(cfg_q[0]) >= `MCS_OFS_MIN && $signed(cfg_q[0]) <= `MCS_OFS_MAX
        && $signed(cfg_q[1]) >= `MCS_OFS_MIN
        && $signed(cfg_q[1]) <= `MCS_OFS_MAX;
    endproperty
    a_ofs_range: assert property (p_ofs_range)
        else $error("offset outside accepted range");

    property p_time_range;
        @(posedge clk_i) disable iff (!rstn_i)
        cfg_q[6] >= `MCS_TIME_MIN && cfg_q[6] <= `MCS_TIME_MAX
        && cfg_q[5] <= `MCS_CUR_MAX;
    endproperty
    a_time_range: assert property (p_time_range)
        else $error("commutation setting outside range");

    property p_static_hold;
        @(posedge clk_i) disable iff (!rstn_i)
        !$past(cfg_reload_i) |-> $stable(static_q);
    endproperty
    a_static_hold: assert property (p_static_hold)
        else $error("static setting changed without reload");

    property p_comm_cur;
        @(posedge clk_i) disable iff (!rstn_i)
        comm_run |=> comm_active_o && comm_current_o == $past(cfg_q[5]);
    endproperty
    a_comm_cur: assert property (p_comm_cur)
        else $error("commutation current not applied");

    property p_home0;
        @(posedge clk_i) disable iff (!rstn_i)
        home_done_i && home_q == mcs_pkg::HM_IDLE && !cfg_q[8][0] |=>
            pos_load_o && !move_req_o && pos_value_o == $past(home_offset_i);
    endproperty
    a_home0: assert property (p_home0)
        else $error("behaviour 0 did not preset home offset");

    property p_home1;
        @(posedge clk_i) disable iff (!rstn_i)
        home_q == mcs_pkg::HM_MOVE && move_done_i |=>
            pos_load_o && pos_value_o == 32'sh0000_0000;
    endproperty
    a_home1: assert property (p_home1)
        else $error("behaviour 1 did not zero position");
endmodule
`default_nettype wire
